// ### baud_divider_defines.svh
// Register map, field positions and counts of the baud divider.
`ifndef BAUD_DIVIDER_DEFINES_SVH
`define BAUD_DIVIDER_DEFINES_SVH

// Byte addresses of the registers on the APB bus.
`define BD_ADDR_LOW   12'h000
`define BD_ADDR_HIGH  12'h004
`define BD_ADDR_CTRL  12'h008
`define BD_ADDR_STAT  12'h00C

// Control register bit positions.
`define BD_CTRL_DBL   0
`define BD_CTRL_SYNC  1

// Reset values of the divisor and counter fields.
`define BD_HIGH_RST   4'h0
`define BD_LOW_RST    8'h00
`define BD_PRESC_RST  12'h000
`define BD_POST_RST   4'h0

// Last count of the post-divider: 16, 8 or 2 rate ticks a bit.
`define BD_POST_ASYNC 4'hF
`define BD_POST_DBL   4'h7
`define BD_POST_SYNC  4'h1

// Constants of the datapath.
`define BD_PRESC_ZERO 12'h000
`define BD_PRESC_ONE  12'h001
`define BD_POST_ONE   4'h1
`define BD_RD_ZERO    16'h0000
// Gap counter start after a write reload or reset: one below zero.
`define BD_GAP_PRELOAD 12'hFFF

`endif

// ### baud_divider_pkg.sv
// Types shared by the baud divider design.
package baud_divider_pkg;

  // All state of the divider, registered as one word.
  typedef struct packed {
    logic [3:0]  div_hi;     // Divisor bits 11:8.
    logic [7:0]  div_lo;     // Divisor bits 7:0.
    logic        dbl;        // Double-speed select.
    logic        sync;       // Synchronous operation.
    logic [11:0] presc;      // Prescaler down-counter.
    logic [3:0]  post;       // Post-divider counter.
    logic        rate_tick;  // Prescaler tick.
    logic        bit_tick;   // Bit-period tick.
    logic [15:0] rd;         // Read data for the access phase.
    logic        err;        // Unmapped address seen in setup.
  } state_s;

  // Outputs toward the transmitter and receiver.
  typedef struct packed {
    logic rate_tick;
    logic bit_tick;
    logic dbl;
    logic sync;
  } rate_out_s;

endpackage : baud_divider_pkg

// ### baud_divider.sv
// Programmable baud-rate divider with an APB register slave.
// Behaviour
// - 12-bit divisor, high nibble plus low byte.
// - Low byte write reloads prescaler at once.
// - Bits 15:12 read zero; divisor resets zero.
// - Rate changes mid-frame corrupt; no protection.
// - Divisor zero gives the highest bit rate.
// - Double speed: post-divider eight, async only.
`timescale 1ns/1ps
`include "baud_divider_defines.svh"

module baud_divider (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output baud_divider_pkg::rate_out_s     rate_out
);

  // Registered state and its next value.
  baud_divider_pkg::state_s q_q;
  baud_divider_pkg::state_s q_d;

  // Setup phase: the slave decodes the address here.
  logic setup;
  // Access phase write, taken at the edge that ends it.
  logic wr;
  // Full 12-bit divisor.
  logic [11:0] div;
  // Divisor after a low write in this cycle.
  logic [11:0] new_div;
  // Last post-divider count for the current mode.
  logic [3:0] post_last;

  // The slave never stretches a transfer.
  assign pready = 1'b1;

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  assign div   = {q_q.div_hi, q_q.div_lo};
  assign new_div = {q_q.div_hi, pwdata[7:0]};

  // Lanes 0 and 1 carry data; bits 31:16 always read zero.
  assign prdata  = {16'h0000, q_q.rd};
  // The error flag is shown only in the access phase.
  assign pslverr = psel && penable && q_q.err;

  // Rate outputs all come from flip-flops.
  assign rate_out.rate_tick = q_q.rate_tick;
  assign rate_out.bit_tick  = q_q.bit_tick;
  assign rate_out.dbl       = q_q.dbl;
  assign rate_out.sync      = q_q.sync;

  // Post-divider length by mode.
  // double speed
  always_comb
  begin
    if (q_q.sync)
    begin
      // Synchronous clocking ignores the double-speed bit.
      post_last = `BD_POST_SYNC;
    end
    else if (q_q.dbl)
    begin
      post_last = `BD_POST_DBL;
    end
    else
    begin
      post_last = `BD_POST_ASYNC;
    end
  end

  // Next-state logic of the whole block.
  always_comb
  begin
    q_d           = q_q;
    q_d.rate_tick = 1'b0;
    q_d.bit_tick  = 1'b0;

    if (q_q.presc == `BD_PRESC_ZERO)
    begin
      // zero divisor
      // A divisor of zero reloads zero and ticks every cycle.
      q_d.rate_tick = 1'b1;
      q_d.presc     = div;
    end
    else
    begin
      q_d.presc = q_q.presc - `BD_PRESC_ONE;
    end

    // The post-divider advances on each prescaler tick.
    if (q_q.rate_tick)
    begin
      if (q_q.post >= post_last)
      begin
        // Wrap also catches a mode change to a shorter length.
        q_d.post     = `BD_POST_RST;
        q_d.bit_tick = 1'b1;
      end
      else
      begin
        q_d.post = q_q.post + `BD_POST_ONE;
      end
    end

    // Register writes, taken at the end of the access phase.
    // no frame protection
    // A rate change mid-frame is applied as written.
    if (wr && pstrb[0])
    begin
      if (paddr == `BD_ADDR_LOW)
      begin
        q_d.div_lo = pwdata[7:0];
        q_d.presc  = new_div;
      end
      else if (paddr == `BD_ADDR_HIGH)
      begin
        // reserved bits dropped
        // Only the nibble is stored; the prescaler keeps counting.
        q_d.div_hi = pwdata[3:0];
      end
      else if (paddr == `BD_ADDR_CTRL)
      begin
        q_d.dbl  = pwdata[`BD_CTRL_DBL];
        q_d.sync = pwdata[`BD_CTRL_SYNC];
      end
      else
      begin
        // Status is read-only; unmapped writes are ignored.
        q_d.div_lo = q_q.div_lo;
      end
    end

    // Read data and error are captured in the setup phase.
    if (setup)
    begin
      q_d.err = 1'b0;
      if (paddr == `BD_ADDR_LOW)
      begin
        q_d.rd = {8'h00, q_q.div_lo};
      end
      else if (paddr == `BD_ADDR_HIGH)
      begin
        q_d.rd = {12'h000, q_q.div_hi};
      end
      else if (paddr == `BD_ADDR_CTRL)
      begin
        q_d.rd = {14'h0000, q_q.sync, q_q.dbl};
      end
      else if (paddr == `BD_ADDR_STAT)
      begin
        // Live counters let software see the divider run.
        q_d.rd = {q_q.post, q_q.presc};
      end
      else
      begin
        q_d.rd  = `BD_RD_ZERO;
        q_d.err = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_q.div_hi    <= `BD_HIGH_RST;
      q_q.div_lo    <= `BD_LOW_RST;
      q_q.dbl       <= 1'b0;
      q_q.sync      <= 1'b0;
      q_q.presc     <= `BD_PRESC_RST;
      q_q.post      <= `BD_POST_RST;
      q_q.rate_tick <= 1'b0;
      q_q.bit_tick  <= 1'b0;
      q_q.rd        <= `BD_RD_ZERO;
      q_q.err       <= 1'b0;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  // Helper: cycles since the last tick or reload.
  // The check below is valid only while the divisor held still.
  logic [11:0] gap_q;        // Cycles counted since the last tick.
  logic        clean_q;      // No high write since the last reload.
  logic        period_ok_q;  // The ending period ran on the present divisor.
  logic        wr_low;       // Low byte write taken at this edge.
  logic        wr_high;      // High byte write taken at this edge.
  logic        reload;       // The prescaler loads a new count at this edge.

  assign wr_low  = wr && pstrb[0] && (paddr == `BD_ADDR_LOW);
  assign wr_high = wr && pstrb[0] && (paddr == `BD_ADDR_HIGH);
  assign reload  = wr_low || (q_q.presc == `BD_PRESC_ZERO);

  // Gap counter used only by the period check.
  // A natural reload comes one edge before the tick that clears the gap,
  // so a write reload or reset starts it one below zero to line up.
  // A high write only takes effect at the next reload, so the period
  // after that reload is the first one that runs on the new divisor.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q       <= `BD_GAP_PRELOAD;
      clean_q     <= 1'b1;
      period_ok_q <= 1'b0;
    end
    else
    begin
      if (wr_low)
      begin
        gap_q <= `BD_GAP_PRELOAD;
      end
      else if (q_q.rate_tick)
      begin
        gap_q <= `BD_PRESC_RST;
      end
      else
      begin
        gap_q <= gap_q + `BD_PRESC_ONE;
      end
      if (reload)
      begin
        // The period now ending is judged on the divisor seen so far.
        clean_q     <= !wr_high;
        period_ok_q <= clean_q && !wr_high;
      end
      else
      begin
        clean_q <= clean_q && !wr_high;
      end
    end
  end

  // A low-byte write in the access phase.
  sequence s_low_write;
    wr_low;
  endsequence

  // The last prescaler tick of a bit period.
  sequence s_last_tick;
    q_q.rate_tick && (q_q.post == post_last);
  endsequence

  a_low_reload: assert property (@(posedge pclk) disable iff (!presetn)
    s_low_write |=> (q_q.presc == $past(new_div)))
    else $error("prescaler not reloaded by low write");

  a_high_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> (q_q.div_hi == $past(pwdata[3:0])))
    else $error("high nibble not stored");

  a_low_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr == `BD_ADDR_LOW) |=> (prdata[7:0] == $past(q_q.div_lo)))
    else $error("low byte read mismatch");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr == `BD_ADDR_HIGH) |=> (prdata[31:4] == 28'h0000000))
    else $error("reserved high bits not zero");

  a_zero_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (div == `BD_PRESC_ZERO && q_q.presc == `BD_PRESC_ZERO && !wr)
      |=> q_q.rate_tick [*2])
    else $error("zero divisor does not tick each cycle");

  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    (q_q.rate_tick && period_ok_q && !$past(wr_low)) |-> (gap_q == div))
    else $error("rate tick period is not divisor plus one");

  a_post_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    s_last_tick |=> (q_q.bit_tick && q_q.post == `BD_POST_RST))
    else $error("bit tick missing at post-divider wrap");

  a_double_len: assert property (@(posedge pclk) disable iff (!presetn)
    (q_q.dbl && !q_q.sync && $past(q_q.dbl) && !$past(q_q.sync)
      && ($past(q_q.post) <= `BD_POST_DBL)) |-> (q_q.post <= `BD_POST_DBL))
    else $error("double speed count runs past eight ticks");

  a_bit_cause: assert property (@(posedge pclk) disable iff (!presetn)
    q_q.bit_tick |-> $past(q_q.rate_tick))
    else $error("bit tick without a rate tick");

  // Unmapped addresses answer with an error.
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr > `BD_ADDR_STAT) |=> (penable |-> pslverr))
    else $error("unmapped access not flagged");

endmodule : baud_divider

// ### testbench.sv
// Self-checking testbench of the baud divider, driven over APB.
`timescale 1ns/1ps
`include "baud_divider_defines.svh"

module testbench;
  logic                        pclk;        // System clock.
  logic                        presetn;     // Active-low reset.
  logic                        psel;        // APB select.
  logic                        penable;     // APB access phase.
  logic                        pwrite;      // APB direction.
  logic [11:0]                 paddr;       // APB byte address.
  logic [31:0]                 pwdata;      // APB write data.
  logic [3:0]                  pstrb;       // APB byte strobes.
  logic [31:0]                 prdata;      // APB read data.
  logic                        pready;      // APB ready.
  logic                        pslverr;     // APB error.
  baud_divider_pkg::rate_out_s rate_out;    // Ticks and mode levels.
  int                          mismatches;  // Failed comparisons.
  int                          tests_run;   // All comparisons.
  logic [31:0]                 rd;          // Data of the last transfer.
  logic                        err;         // Error of the last transfer.
  int                          n;           // Cycles counted by a wait.

  baud_divider i_dut (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pstrb    (pstrb),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .rate_out (rate_out)
  );

  // Free-running clock at 100 MHz.
  always #5 pclk = ~pclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Compares one value; case inequality so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    // A slave that never answers ends the run as a failure.
    if (k >= 50)
    begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Counts cycles up to the next pulse of a tick, sampled mid-cycle.
  task automatic wait_tick(input logic use_bit);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while ((use_bit ? rate_out.bit_tick : rate_out.rate_tick) !== 1'h1 && n < 2000);
    if (n >= 2000)
    begin
      mismatches++;
      end_sim();
    end
  endtask : wait_tick

  // Reset values and the fastest rate with divisor zero.
  task automatic t_reset();
    apb(1'h0, `BD_ADDR_LOW, 32'h0);
    chk("low reset", 32'h0, rd);
    apb(1'h0, `BD_ADDR_HIGH, 32'h0);
    chk("high reset", 32'h0, rd);
    wait_tick(1'h0);
    wait_tick(1'h0);
    chk("rate gap div0", 32'h1, n);
    wait_tick(1'h1);
    wait_tick(1'h1);
    chk("bit gap div0", 32'h10, n);
  endtask : t_reset

  // Reserved high bits read zero; an unmapped read errors.
  task automatic t_high();
    apb(1'h1, `BD_ADDR_HIGH, 32'hFF);
    apb(1'h0, `BD_ADDR_HIGH, 32'h0);
    chk("high reserved", 32'h0F, rd);
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'h0, `BD_ADDR_STAT, 32'h0);
    chk("status err", 32'h0, {31'h0, err});
    // Without lane 0 strobed the write must be dropped.
    pstrb <= 4'h0;
    apb(1'h1, `BD_ADDR_LOW, 32'h55);
    pstrb <= 4'hF;
    apb(1'h0, `BD_ADDR_LOW, 32'h0);
    chk("masked low write", 32'h0, rd);
  endtask : t_high

  // A low write reloads at once with the combined 12-bit divisor.
  task automatic t_reload();
    apb(1'h1, `BD_ADDR_HIGH, 32'h1);
    apb(1'h1, `BD_ADDR_LOW, 32'h2);
    // Counted from the writing edge and sampled half a cycle on: one extra.
    wait_tick(1'h0);
    chk("first gap 0x102", 32'h104, n);
    wait_tick(1'h0);
    chk("gap 0x102", 32'h103, n);
    apb(1'h0, `BD_ADDR_LOW, 32'h0);
    chk("low readback", 32'h2, rd);
  endtask : t_reload

  // Every mode: async, double speed, sync, sync with double speed.
  task automatic t_modes();
    int per [4];
    per = '{32, 16, 4, 4};
    apb(1'h1, `BD_ADDR_HIGH, 32'h0);
    apb(1'h1, `BD_ADDR_LOW, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, `BD_ADDR_CTRL, i);
      // The mode levels change at the writing edge; look half a cycle on.
      @(negedge pclk);
      chk("dbl level", i & 1, {31'h0, rate_out.dbl});
      chk("sync level", i >> 1, {31'h0, rate_out.sync});
      // The first period after a mode change may be partial, so skip it.
      wait_tick(1'h1);
      wait_tick(1'h1);
      wait_tick(1'h1);
      chk("bit gap", per[i], n);
      // Achieved over target rate is target over measured period.
      chk("rate error pct", 32'h0, (per[i] * 100) / n - 100);
    end
  endtask : t_modes

  // Main sequence: reset for five cycles, then the scenarios.
  initial
  begin
    pclk       = 1'h0;
    presetn    = 1'h0;
    psel       = 1'h0;
    penable    = 1'h0;
    pwrite     = 1'h0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    pstrb      = 4'hF;
    mismatches = 0;
    tests_run  = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_high();
    t_reload();
    t_modes();
    end_sim();
  end
endmodule : testbench
